// *** inc/dcm_pkg.sv ***
// Constants, types and register map of the DAC clock multiplier control block.
// Assumes a single 20 MHz system clock and an AHB-Lite register bus.
package dcm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned SETTLE_US       = 100000;
  localparam int unsigned SETTLE_CYC      = (SETTLE_US / 1000) * (CLK_HZ / 1000);
  localparam int unsigned REF_DIV_RST     = 2;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ    = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_REFDIV = 8'h10;

  // CTRL fields.
  localparam int unsigned CTRL_REF_EN  = 0;
  localparam int unsigned CTRL_SYNC    = 1;
  localparam logic [1:0]  CTRL_RST_VAL = 2'h0;

  // Interrupt bit positions.
  localparam int unsigned IRQ_LOCK_GAIN = 0;
  localparam int unsigned IRQ_LOCK_LOSS = 1;
  localparam int unsigned IRQ_ALIGN     = 2;
  localparam int unsigned IRQ_W         = 3;

  // Prescaler codes.
  localparam logic [1:0] PS_PRESCALE_SEL_HI = 2'h0;
  localparam logic [1:0] PS_DIV2 = 2'h1;
  localparam logic [1:0] PS_DIV4 = 2'h2;
  localparam logic [1:0] PS_DIV8 = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    DCM_ST_UNLOCKED,
    DCM_ST_SETTLING,
    DCM_ST_LOCKED
  } dcm_lock_st_t;

  typedef enum logic [1:0] {
    DCM_AL_RUN,
    DCM_AL_HELD,
    DCM_AL_LOW
  } dcm_align_st_t;

endpackage

// *** rtl/dcm_phase_gen.sv ***
// Phase generator: turns a reference edge enable into aligned 1x/2x/4x enables.
// Assumes ref_tick is a one-cycle pulse per 2x or 4x tick, which is 2 or 4 consecutive cycles per reference rising edge in multiplier mode.
`timescale 1ns/1ps
module dcm_phase_gen (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Control.
  input  wire logic ref_tick,
  input  wire logic zero_stuff,
  input  wire logic align_hi,
  input  wire logic align_lo,
  // Phase enables.
  output logic      en_4x,
  output logic      en_2x,
  output logic      en_1x,
  output logic      clk_1x
);
  import dcm_pkg::*;

  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic       hi_r;
  logic       hi_nxt;

  // The reference runs at 4x with zero stuffing and 2x otherwise.
  always_comb begin
    ph_nxt = ph_r;
    hi_nxt = hi_r;
    if (align_hi) begin
      ph_nxt = 2'h0;
      hi_nxt = 1'b1;
    end else if (align_lo) begin
      ph_nxt = 2'h1;
      hi_nxt = 1'b0;
    end else if (ref_tick) begin
      ph_nxt = zero_stuff ? 2'(ph_r + 2'h1) : {1'b0, ~ph_r[0]};
      hi_nxt = zero_stuff ? ~ph_nxt[1] : ~ph_nxt[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ph_r <= 2'h0;
      hi_r <= 1'b1;
    end else begin
      ph_r <= ph_nxt;
      hi_r <= hi_nxt;
    end
  end

  assign en_4x  = ref_tick;
  assign en_2x  = ref_tick & (~zero_stuff | ph_r[0]);
  assign en_1x  = ref_tick & (zero_stuff ? (ph_r == 2'h3) : ph_r[0]);
  assign clk_1x = hi_r;

endmodule

// *** rtl/dcm_clock_ctrl.sv ***
// Clock multiplier control and clock distribution for an interpolating DAC.
// Assumes all pins synchronous to sys_clk and a single AHB-Lite master.
//
// Behaviour
// - Derive aligned 1x, 2x and 4x enables from one reference.
// - Multiplier mode accepts a reference at the input data rate.
// - Supply strap high enables the multiplier, low bypasses it.
// - Without zero stuffing, codes 00..11 divide by 1, 2, 4, 8.
// - With zero stuffing the same codes still divide by 1, 2, 4, 8.
// - Lock indicator goes high once the loop has locked.
// - Lock indicator may toggle freely before lock.
// - In bypass distribution stays active; 1x clock drives lock indicator pin.
// - In bypass data is captured on alternate reference rising edges, every fourth with zero stuffing.
// - Capture edge is the one before the 1x clock rising edge.
// - Multiplier mode aligns devices itself; bypass aligns by reset.
// - Zero stuffing inserts midscale after each interpolated sample.
// - Bypass reset forces 1x high, low next edge, high again loading latches; with zero stuffing 1x stays low at that load.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module dcm_clock_ctrl #(
  parameter int unsigned SETTLE_CYCLES = dcm_pkg::SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Device pins.
  input  wire logic        ref_clk_in,
  input  wire logic        multiplier_supply_strap,
  input  wire logic        prescale_sel_hi,
  input  wire logic        prescale_sel_lo,
  input  wire logic        zero_stuff_sel,
  input  wire logic        mix_mode_sel,
  input  wire logic        align_reset,
  output logic             lock_indicator,
  // Internal clock enables.
  output logic             en_4x,
  output logic             en_2x,
  output logic             en_1x,
  output logic             latch_load,
  output logic             midscale_ins,
  output logic [3:0]       divide_ratio,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt.
  output logic             irq
);
  import dcm_pkg::*;

  // ****************************************
  // Strap capture and mode
  // ****************************************
  logic pll_mode_r;
  logic pll_mode_nxt;
  logic ref_d_r;
  logic ref_d_nxt;
  logic zs_r;
  logic zs_nxt;
  logic [1:0] ps_r;
  logic [1:0] ps_nxt;

  // The strap is sampled each cycle after reset release.
  always_comb begin
    pll_mode_nxt = multiplier_supply_strap;
    ref_d_nxt    = ref_clk_in;
    zs_nxt       = zero_stuff_sel;
    ps_nxt       = {prescale_sel_hi, prescale_sel_lo};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pll_mode_r <= 1'b0;
      ref_d_r    <= 1'b0;
      zs_r       <= 1'b0;
      ps_r       <= PS_PRESCALE_SEL_HI;
    end else begin
      pll_mode_r <= pll_mode_nxt;
      ref_d_r    <= ref_d_nxt;
      zs_r       <= zs_nxt;
      ps_r       <= ps_nxt;
    end
  end

  function automatic logic [3:0] ratio_of(input logic [1:0] code);
    case (code)
      PS_PRESCALE_SEL_HI: ratio_of = 4'h1;
      PS_DIV2: ratio_of = 4'h2;
      PS_DIV4: ratio_of = 4'h4;
      default: ratio_of = 4'h8;
    endcase
  endfunction

  // ****************************************
  // Reference edge and multiplier model
  // ****************************************
  logic       ref_rise;
  logic [1:0] mul_cnt_r;
  logic [1:0] mul_cnt_nxt;
  logic       ref_tick;
  logic       ref_en_r;

  assign ref_rise = ref_clk_in & ~ref_d_r;

  // In multiplier mode the reference is at the data rate, so each edge
  // is spread into 2 or 4 output ticks on a fixed schedule.
  always_comb begin
    mul_cnt_nxt = mul_cnt_r;
    if (pll_mode_r) begin
      if (ref_rise) begin
        mul_cnt_nxt = zs_r ? 2'h3 : 2'h1;
      end else if (mul_cnt_r != 2'h0) begin
        mul_cnt_nxt = 2'(mul_cnt_r - 2'h1);
      end
    end else begin
      mul_cnt_nxt = 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mul_cnt_r <= 2'h0;
    end else begin
      mul_cnt_r <= mul_cnt_nxt;
    end
  end

  // Bypass takes each reference edge as a 2x or 4x tick.
  assign ref_tick = ref_en_r & (pll_mode_r ? (ref_rise | mul_cnt_r != 2'h0) : ref_rise);

  // ****************************************
  // Lock tracking
  // ****************************************
  dcm_lock_st_t lk_st_r;
  dcm_lock_st_t lk_st_nxt;
  logic [31:0]  lk_cnt_r;
  logic [31:0]  lk_cnt_nxt;
  logic [1:0]   lk_ps_r;
  logic [1:0]   lk_ps_nxt;
  logic         locked;

  always_comb begin
    lk_st_nxt  = lk_st_r;
    lk_cnt_nxt = lk_cnt_r;
    lk_ps_nxt  = ps_r;
    case (lk_st_r)
      DCM_ST_UNLOCKED: begin
        lk_cnt_nxt = 32'h0;
        if (pll_mode_r && ref_en_r && ref_rise) begin
          lk_st_nxt = DCM_ST_SETTLING;
        end
      end
      DCM_ST_SETTLING: begin
        lk_cnt_nxt = lk_cnt_r + 32'h1;
        if (lk_cnt_r >= 32'(SETTLE_CYCLES) - 32'h1) begin
          lk_st_nxt = DCM_ST_LOCKED;
        end
      end
      default: begin
        lk_cnt_nxt = 32'h0;
      end
    endcase
    // Losing the strap, reference enable or prescaler setting drops lock.
    if (!pll_mode_r || !ref_en_r || lk_ps_r != ps_r) begin
      lk_st_nxt  = DCM_ST_UNLOCKED;
      lk_cnt_nxt = 32'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lk_st_r  <= DCM_ST_UNLOCKED;
      lk_cnt_r <= 32'h0;
      lk_ps_r  <= PS_PRESCALE_SEL_HI;
    end else begin
      lk_st_r  <= lk_st_nxt;
      lk_cnt_r <= lk_cnt_nxt;
      lk_ps_r  <= lk_ps_nxt;
    end
  end

  assign locked = (lk_st_r == DCM_ST_LOCKED);

  // ****************************************
  // Reset alignment in bypass
  // ****************************************
  dcm_align_st_t al_st_r;
  dcm_align_st_t al_st_nxt;
  logic          align_hi;
  logic          align_lo;
  logic          align_done;
  logic          clk_1x;

  always_comb begin
    al_st_nxt  = al_st_r;
    align_hi   = 1'b0;
    align_lo   = 1'b0;
    align_done = 1'b0;
    case (al_st_r)
      DCM_AL_RUN: begin
        if (align_reset && !pll_mode_r) begin
          al_st_nxt = DCM_AL_HELD;
          align_hi  = 1'b1;
        end
      end
      DCM_AL_HELD: begin
        align_hi = 1'b1;
        if (!align_reset && ref_tick) begin
          align_hi  = 1'b0;
          align_lo  = 1'b1;
          al_st_nxt = DCM_AL_LOW;
        end
      end
      default: begin
        if (ref_tick) begin
          align_done = 1'b1;
          al_st_nxt  = DCM_AL_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      al_st_r <= DCM_AL_RUN;
    end else begin
      al_st_r <= al_st_nxt;
    end
  end

  dcm_phase_gen u_phase (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .ref_tick   (ref_tick),
    .zero_stuff (zs_r),
    .align_hi   (align_hi),
    .align_lo   (align_lo),
    .en_4x      (en_4x),
    .en_2x      (en_2x),
    .en_1x      (en_1x),
    .clk_1x     (clk_1x)
  );

  // Latches load on the tick that raises the 1x clock, save the alignment load under zero stuffing, which leaves it low.
  assign latch_load = en_1x | align_done;

  // ****************************************
  // Registered outputs
  // ****************************************
  logic       lock_out_r;
  logic       lock_out_nxt;
  logic       mid_r;
  logic       mid_nxt;
  logic [3:0] ratio_r;
  logic [3:0] ratio_nxt;

  always_comb begin
    // While settling, the pin shows bit 4 of the settling count as a toggling level.
    if (pll_mode_r) begin
      lock_out_nxt = locked | (lk_st_r == DCM_ST_SETTLING & lk_cnt_r[4]);
    end else begin
      lock_out_nxt = clk_1x;
    end
    // Midscale goes out on every second 4x tick.
    mid_nxt   = zs_r & ~mid_r & ref_tick ? 1'b1 : (ref_tick ? 1'b0 : mid_r);
    ratio_nxt = ratio_of(ps_r);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_out_r <= 1'b0;
      mid_r      <= 1'b0;
      ratio_r    <= 4'h1;
    end else begin
      lock_out_r <= lock_out_nxt;
      mid_r      <= mid_nxt;
      ratio_r    <= ratio_nxt;
    end
  end

  assign lock_indicator = lock_out_r;
  assign midscale_ins   = mid_r & zs_r;
  assign divide_ratio   = ratio_r;

  // ****************************************
  // Register file and interrupts
  // ****************************************
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_st_nxt;
  logic [IRQ_W-1:0] irq_mk_r;
  logic [IRQ_W-1:0] irq_mk_nxt;
  logic [IRQ_W-1:0] ev;
  logic             locked_d_r;
  logic             sync_r;
  logic             sync_nxt;
  logic             ref_en_nxt;
  logic [7:0]       refdiv_r;
  logic [7:0]       refdiv_nxt;
  logic             wr_pend_r;
  logic             wr_pend_nxt;
  logic [7:0]       wr_addr_r;
  logic [7:0]       wr_addr_nxt;
  logic [31:0]      rdata_nxt;
  logic [31:0]      rdata_r;
  logic             acc;

  assign acc = hsel & hready & htrans[1];
  assign ev  = {align_done, locked_d_r & ~locked, locked & ~locked_d_r};

  always_comb begin
    wr_pend_nxt = acc & hwrite;
    wr_addr_nxt = haddr[7:0];
    irq_mk_nxt  = irq_mk_r;
    ref_en_nxt  = ref_en_r;
    sync_nxt    = sync_r;
    refdiv_nxt  = refdiv_r;
    irq_st_nxt  = irq_st_r;
    if (wr_pend_r) begin
      if (wr_addr_r == ADDR_CTRL) begin
        ref_en_nxt = hwdata[CTRL_REF_EN];
        sync_nxt   = hwdata[CTRL_SYNC];
      end else if (wr_addr_r == ADDR_IRQ) begin
        irq_st_nxt = irq_st_r & ~hwdata[IRQ_W-1:0];
      end else if (wr_addr_r == ADDR_MASK) begin
        irq_mk_nxt = hwdata[IRQ_W-1:0];
      end else if (wr_addr_r == ADDR_REFDIV) begin
        refdiv_nxt = hwdata[7:0];
      end
    end
    // Setting wins over a clear in the same cycle.
    irq_st_nxt = irq_st_nxt | ev;
    rdata_nxt  = 32'h0;
    if (wr_addr_nxt == ADDR_CTRL) begin
      rdata_nxt = {30'h0, sync_r, ref_en_r};
    end else if (wr_addr_nxt == ADDR_STATUS) begin
      rdata_nxt = {16'h0, ratio_r, 2'h0, ps_r, 1'h0, mix_mode_sel, zs_r, pll_mode_r,
                   2'h0, lock_out_r, locked};
    end else if (wr_addr_nxt == ADDR_IRQ) begin
      rdata_nxt = {29'h0, irq_st_r};
    end else if (wr_addr_nxt == ADDR_MASK) begin
      rdata_nxt = {29'h0, irq_mk_r};
    end else if (wr_addr_nxt == ADDR_REFDIV) begin
      rdata_nxt = {24'h0, refdiv_r};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_pend_r  <= 1'b0;
      wr_addr_r  <= 8'h0;
      irq_st_r   <= 3'h0;
      irq_mk_r   <= 3'h0;
      ref_en_r   <= 1'b1;
      sync_r     <= 1'b0;
      refdiv_r   <= 8'(REF_DIV_RST);
      rdata_r    <= 32'h0;
      locked_d_r <= 1'b0;
    end else begin
      wr_pend_r  <= wr_pend_nxt;
      wr_addr_r  <= wr_addr_nxt;
      irq_st_r   <= irq_st_nxt;
      irq_mk_r   <= irq_mk_nxt;
      ref_en_r   <= ref_en_nxt;
      sync_r     <= sync_nxt;
      refdiv_r   <= refdiv_nxt;
      rdata_r    <= acc ? rdata_nxt : rdata_r;
      locked_d_r <= locked;
    end
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(irq_st_r & irq_mk_r);

endmodule

// *** sim/dcm_clock_ctrl_assertions.sv ***
// Checker of the clock control block, bound to its ports.
// Assumes one clock domain, sys_clk with synchronous rst_n.
`timescale 1ns/1ps
module dcm_clock_ctrl_assertions (
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Pins and enables.
  input wire logic       multiplier_supply_strap,
  input wire logic       prescale_sel_hi,
  input wire logic       prescale_sel_lo,
  input wire logic       zero_stuff_sel,
  input wire logic       align_reset,
  input wire logic       lock_indicator,
  input wire logic       en_4x,
  input wire logic       en_2x,
  input wire logic       en_1x,
  input wire logic       latch_load,
  input wire logic       midscale_ins,
  input wire logic [3:0] divide_ratio
);
  import dcm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ********
  // Helpers
  // ********
  // Counts 2x enables between 1x enables once the phase has settled.
  logic [4:0] cfg_now;
  logic [4:0] cfg_r;
  logic [1:0] n2_r;
  logic [1:0] n2_nxt;
  logic [1:0] seen_r;
  logic [1:0] seen_nxt;
  assign cfg_now = {multiplier_supply_strap, zero_stuff_sel, prescale_sel_hi,
                    prescale_sel_lo, align_reset};
  always_comb begin
    n2_nxt = en_1x ? 2'h0 : n2_r + {1'b0, en_2x};
    seen_nxt = seen_r;
    if (cfg_now != cfg_r || align_reset) begin
      seen_nxt = 2'h0;
    end else if (en_1x && seen_r != 2'h3) begin
      seen_nxt = seen_r + 2'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      n2_r <= 2'h0;
      seen_r <= 2'h0;
      cfg_r <= 5'h00;
    end else begin
      n2_r <= n2_nxt;
      seen_r <= seen_nxt;
      cfg_r <= cfg_now;
    end
  end
  // ********
  // Checks
  // ********
  a_ratio_code: assert property ($past(rst_n) && $past(rst_n, 2)
    && $stable({prescale_sel_hi, prescale_sel_lo})
    && $past({prescale_sel_hi, prescale_sel_lo}, 2) == {prescale_sel_hi, prescale_sel_lo}
    |-> divide_ratio == (4'h1 << {prescale_sel_hi, prescale_sel_lo}))
    else $error("divide ratio differs from the prescaler code");
  a_one_in_two: assert property (seen_r == 2'h3 && en_1x |-> n2_r == 2'h1)
    else $error("1x enable not on every other 2x enable");
  a_nest_2x: assert property (en_1x |-> en_2x)
    else $error("1x enable without 2x enable");
  a_latch_1x: assert property (latch_load |-> en_1x)
    else $error("latch load off the 1x enable");
  a_pin_follow: assert property (!multiplier_supply_strap[*3] ##0 latch_load
    |-> ##[1:2] $rose(lock_indicator))
    else $error("lock pin did not rise after the capture edge");
  a_align_high: assert property ((align_reset && !multiplier_supply_strap)[*4]
    |-> lock_indicator)
    else $error("alignment reset did not force the 1x clock high");
  a_midscale_off: assert property (!zero_stuff_sel[*3] |-> !midscale_ins)
    else $error("midscale slot while zero stuffing is off");
  a_midscale_step: assert property (zero_stuff_sel[*3] ##0 $changed(midscale_ins)
    |-> $past(en_4x))
    else $error("midscale slot changed off the 4x enable");
endmodule

// *** sim/dcm_ref_source.sv ***
// Reference clock source model for the block's reference input.
// Assumes sys_clk is the bench clock; the output stands low when stopped.
`timescale 1ns/1ps
module dcm_ref_source #(
  parameter int unsigned HALF = 4
) (
  // Clock.
  input wire logic sys_clk,
  // Control.
  input wire logic run,
  // Reference.
  output logic     ref_clk
);
  int unsigned cnt = 0;
  initial ref_clk = 1'b0;
  // One fixed rate serves as the 2x or 4x clock in bypass.
  always @(posedge sys_clk) begin
    if (!run) begin
      cnt <= 0;
      ref_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ref_clk <= ~ref_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** sim/dcm_clock_ctrl_bench.sv ***
// Self-checking bench of the clock control block.
// Assumes the package, the design, the reference model and the checker.
`timescale 1ns/1ps
module dcm_clock_ctrl_bench;
  import dcm_pkg::*;
  logic        sys_clk, rst_n, ref_run, ref_clk_in, multiplier_supply_strap;
  logic        prescale_sel_hi, prescale_sel_lo, zero_stuff_sel, mix_mode_sel;
  logic        align_reset, lock_indicator, en_4x, en_2x, en_1x, latch_load;
  logic        midscale_ins, irq, hsel, hwrite, hreadyout, hresp, lk, saw_low;
  logic [3:0]  divide_ratio;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  wire logic   hready = hreadyout;
  int          n_mismatch, num_checks, c1, c2, c4, cm, cl, k;
  int          e1[4] = '{4, 2, 8, 8};
  dcm_clock_ctrl #(.SETTLE_CYCLES(50)) i_dut (.sys_clk, .rst_n, .ref_clk_in,
    .multiplier_supply_strap, .prescale_sel_hi, .prescale_sel_lo, .zero_stuff_sel,
    .mix_mode_sel, .align_reset, .lock_indicator, .en_4x, .en_2x, .en_1x, .latch_load,
    .midscale_ins, .divide_ratio, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .irq);
  dcm_ref_source #(.HALF(4)) i_ref (.sys_clk, .run(ref_run), .ref_clk(ref_clk_in));
  always #25 sys_clk = ~sys_clk;
  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wait_rdy();
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // One AHB-Lite single word transfer; read data lands in rdat.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdat = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rdat, exp);
  endtask
  task automatic wait_lock();
    k = 0;
    do begin
      bus(ADDR_STATUS, 1'b0, 32'h0);
      k++;
    end while (rdat[0] !== 1'b1 && k < 100);
    if (rdat[0] !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // Waits for a 1x enable if asked, then counts enables and lock pin rises.
  task automatic count(input int n, input logic wait_1x);
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (wait_1x && en_1x !== 1'b1 && k < 100);
    if (wait_1x) check(en_1x, 1'b1);
    {c1, c2, c4, cm, cl} = '0;
    lk = lock_indicator;
    repeat (n) begin
      @(negedge sys_clk);
      c1 += (en_1x === 1'b1);
      c2 += (en_2x === 1'b1);
      c4 += (en_4x === 1'b1);
      cm += (midscale_ins === 1'b1);
      cl += (lock_indicator === 1'b1 && lk === 1'b0);
      lk = lock_indicator;
    end
    @(posedge sys_clk);
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    {sys_clk, rst_n, prescale_sel_hi, prescale_sel_lo, zero_stuff_sel} = '0;
    {mix_mode_sel, align_reset, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {ref_run, multiplier_supply_strap, hsize} = {2'h3, 3'h2};
    {n_mismatch, num_checks} = '0;
    tick(6);
    rst_n <= 1'b1;
    rd_chk(ADDR_CTRL, 32'h1);
    rd_chk(ADDR_REFDIV, 32'h2);
    rd_chk(ADDR_MASK, 32'h0);
    bus(ADDR_REFDIV, 1'b1, 32'ha5);
    rd_chk(ADDR_REFDIV, 32'ha5);
    bus(8'h20, 1'b1, 32'hff);
    rd_chk(8'h20, 32'h0);
    check(hresp, 1'b0);
    for (int c = 0; c < 8; c++) begin
      {zero_stuff_sel, prescale_sel_hi, prescale_sel_lo} <= c[2:0];
      mix_mode_sel <= c[0];
      tick(4);
      check(divide_ratio, 32'h1 << c[1:0]);
      bus(ADDR_STATUS, 1'b0, 32'h0);
      check({rdat[15:12], rdat[9:8], rdat[6:5]}, {4'h1 << c[1:0], c[1:0], c[0], c[2]});
    end
    {zero_stuff_sel, prescale_sel_hi, prescale_sel_lo, mix_mode_sel} <= '0;
    wait_lock();
    bus(ADDR_IRQ, 1'b1, 32'h7);
    bus(ADDR_MASK, 1'b1, 32'h3);
    prescale_sel_lo <= 1'b1;
    tick(3);
    rd_chk(ADDR_STATUS, {16'h0, 4'h2, 2'h0, 2'h1, 8'h10});
    wait_lock();
    rd_chk(ADDR_IRQ, 32'h3);
    repeat (3) begin
      tick(5);
      check(lock_indicator, 1'b1);
    end
    check(irq, 1'b1);
    bus(ADDR_IRQ, 1'b1, 32'h3);
    tick(2);
    check(irq, 1'b0);
    bus(ADDR_CTRL, 1'b1, 32'h0);
    count(40, 1'b0);
    check(c2, 0);
    bus(ADDR_CTRL, 1'b1, 32'h1);
    for (int m = 0; m < 4; m++) begin
      {multiplier_supply_strap, zero_stuff_sel} <= m[1:0];
      tick(10);
      bus(ADDR_STATUS, 1'b0, 32'h0);
      check(rdat[5:4], {m[0], m[1]});
      count(64, 1'b1);
      check(c1, e1[m]);
      check(c2, 2 * e1[m]);
      check(c4, (m[0] ? 4 : 2) * e1[m]);
      check(cm != 0, m[0]);
      if (!m[1]) check(cl, e1[m]);
    end
    multiplier_supply_strap <= 1'b0;
    zero_stuff_sel <= 1'b0;
    tick(10);
    bus(ADDR_IRQ, 1'b1, 32'h7);
    bus(ADDR_MASK, 1'b1, 32'h0);
    align_reset <= 1'b1;
    tick(6);
    check(lock_indicator, 1'b1);
    align_reset <= 1'b0;
    saw_low = 1'b0;
    k = 0;
    do begin
      @(negedge sys_clk);
      saw_low |= (lock_indicator === 1'b0);
      k++;
    end while (latch_load !== 1'b1 && k < 100);
    check(latch_load, 1'b1);
    check(saw_low, 1'b1);
    tick(3);
    check(lock_indicator, 1'b1);
    check(irq, 1'b0);
    rd_chk(ADDR_IRQ, 32'h4);
    bus(ADDR_MASK, 1'b1, 32'h4);
    tick(2);
    check(irq, 1'b1);
    bus(ADDR_IRQ, 1'b1, 32'h4);
    tick(2);
    check(irq, 1'b0);
    conclude();
  end
endmodule
bind dcm_clock_ctrl dcm_clock_ctrl_assertions i_chk (.sys_clk, .rst_n,
  .multiplier_supply_strap, .prescale_sel_hi, .prescale_sel_lo, .zero_stuff_sel,
  .align_reset, .lock_indicator, .en_4x, .en_2x, .en_1x, .latch_load, .midscale_ins,
  .divide_ratio);
